// ===== common/lcr_regs.svh
// Offsets, field positions, reset values and timing for the link control register.
// Assumes a 100 MHz clock and an 8-bit AXI4-Lite byte address.
`ifndef LCR_REGS_SVH
`define LCR_REGS_SVH

`define LCR_ADDR_W          8
`define LCR_ADDR_LINK_CTRL  8'h44
`define LCR_RESET_VALUE     16'h0000

`define LCR_BIT_ADDR64      15
`define LCR_BIT_NXA_EXTCTL  14
`define LCR_BIT_OVF_TRI     13
`define LCR_BIT_PROTO_ISOC  12
`define LCR_CRC_MSB         11
`define LCR_CRC_LSB         8
`define LCR_BIT_XMIT_OFF    7
`define LCR_BIT_EOC         6
`define LCR_BIT_INIT_DONE   5
`define LCR_BIT_LINK_FAIL   4
`define LCR_BIT_CRC_FORCE   3
`define LCR_BIT_CRC_TEST    2
`define LCR_BIT_SYNC_FLOOD  1

`define LCR_ADDR_LIMIT_MSB  39

`define LCR_CLK_PERIOD_NS   10
`define LCR_CTL_EXT_TIME_US 50

`define LCR_RESP_OKAY       2'h0
`define LCR_RESP_SLVERR     2'h2

`endif

// ===== common/lcr_pkg.sv
// Types shared by the link control register and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package lcr_pkg;

  typedef enum logic [1:0] {
    BASIC_SINGLE_PROFILE    = 2'b00,
    EXTENDED_SINGLE_PROFILE = 2'b01,
    EXTENDED_DUAL_PROFILE   = 2'b10
  } profile_e;

  typedef struct packed {
    logic       eoc_drop;
    logic       overflow;
    logic       protocol;
    logic [3:0] crc_lane;
    logic       hw_fail;
    logic       init_done;
    logic       crc_test_done;
    logic       stop_reinit;
  } link_events_s;

  typedef struct packed {
    logic [63:0] addr;
    logic        from_parallel;
    logic        addr_ext_cmd;
  } req_s;

  typedef struct packed {
    logic done;
    logic accept;
    logic forward_ext;
    logic master_abort;
  } req_result_s;

  typedef struct packed {
    logic transmitter_shutdown_flag;
    logic end_of_chain;
    logic link_failure_flag;
    logic link_init_allowed;
    logic force_bad_crc;
    logic crc_test_run;
    logic sync_flood;
    logic tristate_on_stop;
    logic ctl_extend;
    logic addr64_enable;
  } link_ctrl_s;

endpackage : lcr_pkg

// ===== rtl/link_control_register.sv
// Link control and status register with AXI4-Lite access and link-side decisions.
// Assumes events, requests, straps and warm reset come from logic on aclk.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Extended: with bit 15 set, accept high link requests carrying address extension.
// - Bit 15 clear: master-abort link requests above the 40-bit limit.
// - Parallel-side high requests: abort if bit 15 clear, else forward extended.
// - Basic: bit 14 sets on end-of-chain drop, write-1 clears, survives warm reset.
// - Extended: bit 14 set holds link control asserted 50 us after stop reinit.
// - Basic: bit 13 sets on overflow, write-1 clears, survives warm reset.
// - Extended: bit 13 set tristates transmitter during stop sequence, else drives.
// - Basic: bit 12 sets on protocol error, write-1 clears, survives warm reset.
// - Extended: bit 12 isochronous enable unsupported, reads zero.
// - Bits 11:8 per-lane CRC error flags, each cleared by writing one.
// - Bit 7 shuts transmitter off; software sets only; warm or cold reset clears.
// - End of chain set: drop packets to this link, answer nonposted with errors.
// - End of chain software-settable only; warm reset clears it.
// - Bit 5 reads one once low-level link initialization has completed.
// - Link failure set by hardware or software, survives warm reset, blocks init.
// - Software writes to link failure take effect only at next warm reset.
// - Bit 3 forces bad CRC on outgoing traffic; warm reset clears it.
// - Writing one to bit 2 starts CRC test; hardware clears when done.
// - Bit 1: CRC error becomes fatal, floods sync and sets link failure.
module link_control_register #(
  parameter int CTL_EXT_CYCLES =
    (`LCR_CTL_EXT_TIME_US * 1000 + `LCR_CLK_PERIOD_NS - 1) / `LCR_CLK_PERIOD_NS
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   warm_reset,
  input  wire lcr_pkg::profile_e      profile_strap,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`LCR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`LCR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  input  wire lcr_pkg::link_events_s  events,
  input  wire logic                   req_valid,
  input  wire lcr_pkg::req_s          req,
  input  wire logic                   pkt_valid,
  input  wire logic                   pkt_nonposted,
  output lcr_pkg::link_ctrl_s         ctrl,
  output lcr_pkg::req_result_s        req_result,
  output logic                        pkt_drop,
  output logic                        pkt_nxa_response
);
  import lcr_pkg::*;

  localparam logic [12:0] CTL_LOAD = 13'(CTL_EXT_CYCLES - 1);

  function automatic logic sticky(input logic flag, input logic set, input logic clr);
    sticky = set | (flag & ~clr);
  endfunction : sticky

  function automatic logic is_extended(input profile_e p);
    is_extended = (p == EXTENDED_SINGLE_PROFILE) || (p == EXTENDED_DUAL_PROFILE);
  endfunction : is_extended

  //////////////////////////////////////////////////////////////////////////////
  // State

  profile_e           profile;
  logic               ext;
  logic               addr64_en;
  logic               nxa_err;
  logic               ovf_err;
  logic               proto_err;
  logic               ext_ctl_time;
  logic               tristate_en;
  logic [3:0]         crc_err;
  logic               xmit_off;
  logic               eoc;
  logic               init_done;
  logic               link_fail;
  logic               link_fail_sw;
  logic               crc_force;
  logic               crc_test;
  logic               flood_en;
  logic               flooding;
  logic [12:0]        ctl_count;
  logic               ctl_active;
  logic [15:0]        reg_value;

  logic               aw_have;
  logic               w_have;
  logic [`LCR_ADDR_W-1:0] aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               next_aw_have;
  logic               next_w_have;
  logic               next_bvalid;
  logic               do_write;
  logic               wr_lo;
  logic               wr_hi;
  logic               crc_hit;

  assign ext = is_extended(profile);

  //////////////////////////////////////////////////////////////////////////////
  // Profile strap, caught while reset is held

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      profile <= profile_strap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign do_write = aw_have && w_have && !s_axi_bvalid;
  assign wr_lo    = do_write && (aw_addr == `LCR_ADDR_LINK_CTRL) && w_strb[0];
  assign wr_hi    = do_write && (aw_addr == `LCR_ADDR_LINK_CTRL) && w_strb[1];

  always_comb begin
    next_aw_have = aw_have;
    next_w_have  = w_have;
    next_bvalid  = s_axi_bvalid;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
    end
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LCR_RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      aw_have       <= next_aw_have;
      w_have        <= next_w_have;
      s_axi_awready <= !next_aw_have && !next_bvalid;
      s_axi_wready  <= !next_w_have && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= (aw_addr == `LCR_ADDR_LINK_CTRL) ? `LCR_RESP_OKAY : `LCR_RESP_SLVERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `LCR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (s_axi_araddr == `LCR_ADDR_LINK_CTRL) begin
        s_axi_rdata <= {16'h0000, reg_value};
        s_axi_rresp <= `LCR_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `LCR_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read image

  always_comb begin
    reg_value = `LCR_RESET_VALUE;
    reg_value[`LCR_BIT_ADDR64]     = ext & addr64_en;
    reg_value[`LCR_BIT_NXA_EXTCTL] = ext ? ext_ctl_time : nxa_err;
    reg_value[`LCR_BIT_OVF_TRI]    = ext ? tristate_en : ovf_err;
    reg_value[`LCR_BIT_PROTO_ISOC] = ext ? 1'b0 : proto_err;
    reg_value[`LCR_CRC_MSB:`LCR_CRC_LSB] = crc_err;
    reg_value[`LCR_BIT_XMIT_OFF]   = xmit_off;
    reg_value[`LCR_BIT_EOC]        = eoc;
    reg_value[`LCR_BIT_INIT_DONE]  = init_done;
    reg_value[`LCR_BIT_LINK_FAIL]  = link_fail;
    reg_value[`LCR_BIT_CRC_FORCE]  = crc_force;
    reg_value[`LCR_BIT_CRC_TEST]   = crc_test;
    reg_value[`LCR_BIT_SYNC_FLOOD] = flood_en;
    reg_value[0]                   = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Basic-profile sticky error flags, kept over warm reset

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nxa_err   <= 1'b0;
      ovf_err   <= 1'b0;
      proto_err <= 1'b0;
    end else if (!ext) begin
      nxa_err   <= sticky(nxa_err, events.eoc_drop,
                          wr_hi && w_data[`LCR_BIT_NXA_EXTCTL]);
      ovf_err   <= sticky(ovf_err, events.overflow,
                          wr_hi && w_data[`LCR_BIT_OVF_TRI]);
      proto_err <= sticky(proto_err, events.protocol,
                          wr_hi && w_data[`LCR_BIT_PROTO_ISOC]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Extended-profile controls, cleared by warm reset

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      addr64_en    <= 1'b0;
      ext_ctl_time <= 1'b0;
      tristate_en  <= 1'b0;
    end else if (ext && wr_hi) begin
      addr64_en    <= w_data[`LCR_BIT_ADDR64];
      ext_ctl_time <= w_data[`LCR_BIT_NXA_EXTCTL];
      tristate_en  <= w_data[`LCR_BIT_OVF_TRI];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-lane CRC error flags

  assign crc_hit = |events.crc_lane;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_err <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        crc_err[i] <= sticky(crc_err[i], events.crc_lane[i],
                             wr_hi && w_data[`LCR_CRC_LSB + i]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Set-only controls: transmitter shutdown and end of chain

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      xmit_off <= 1'b0;
      eoc      <= 1'b0;
    end else if (wr_lo) begin
      xmit_off <= xmit_off | w_data[`LCR_BIT_XMIT_OFF];
      eoc      <= eoc | w_data[`LCR_BIT_EOC];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Initialization status

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      init_done <= 1'b0;
    end else begin
      init_done <= events.init_done && !link_fail;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link failure: hardware sets now, software value waits for warm reset

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_fail    <= 1'b0;
      link_fail_sw <= 1'b0;
    end else if (warm_reset) begin
      link_fail    <= link_fail_sw;
    end else begin
      if (events.hw_fail || (flood_en && crc_hit)) begin
        link_fail    <= 1'b1;
        link_fail_sw <= 1'b1;
      end else if (wr_lo) begin
        link_fail_sw <= w_data[`LCR_BIT_LINK_FAIL];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // CRC force, test and sync-flood controls

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      crc_force <= 1'b0;
      flood_en  <= 1'b0;
      crc_test  <= 1'b0;
    end else begin
      if (wr_lo) begin
        crc_force <= w_data[`LCR_BIT_CRC_FORCE];
        flood_en  <= w_data[`LCR_BIT_SYNC_FLOOD];
      end
      crc_test <= (wr_lo && w_data[`LCR_BIT_CRC_TEST]) ||
                  (crc_test && !events.crc_test_done);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      flooding <= 1'b0;
    end else if (flood_en && crc_hit) begin
      flooding <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Extended control-assert time after stop reinitialization

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      ctl_count  <= 13'h0000;
      ctl_active <= 1'b0;
    end else if (events.stop_reinit && ext && ext_ctl_time) begin
      ctl_count  <= CTL_LOAD;
      ctl_active <= 1'b1;
    end else if (ctl_active) begin
      if (ctl_count == 13'h0000) begin
        ctl_active <= 1'b0;
      end else begin
        ctl_count <= ctl_count - 13'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request decisions against the 40-bit limit

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_result <= '0;
    end else begin
      req_result <= '0;
      if (req_valid) begin
        req_result.done <= 1'b1;
        if (req.addr[63:`LCR_ADDR_LIMIT_MSB+1] == '0) begin
          req_result.accept <= 1'b1;
        end else if (!(ext && addr64_en)) begin
          req_result.master_abort <= 1'b1;
        end else if (req.from_parallel) begin
          req_result.accept      <= 1'b1;
          req_result.forward_ext <= 1'b1;
        end else if (req.addr_ext_cmd) begin
          req_result.accept <= 1'b1;
        end else begin
          req_result.master_abort <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Packets toward this link while it is the end of chain

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_drop         <= 1'b0;
      pkt_nxa_response <= 1'b0;
    end else begin
      pkt_drop         <= pkt_valid && eoc;
      pkt_nxa_response <= pkt_valid && eoc && pkt_nonposted;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
    end else begin
      ctrl.transmitter_shutdown_flag <= xmit_off;
      ctrl.end_of_chain              <= eoc;
      ctrl.link_failure_flag         <= link_fail;
      ctrl.link_init_allowed         <= !link_fail && !warm_reset;
      ctrl.force_bad_crc             <= crc_force;
      ctrl.crc_test_run              <= crc_test;
      ctrl.sync_flood                <= flooding;
      ctrl.tristate_on_stop          <= ext && tristate_en;
      ctrl.ctl_extend                <= ctl_active;
      ctrl.addr64_enable             <= ext && addr64_en;
    end
  end

endmodule : link_control_register
`default_nettype wire

// ===== dv/lcr_link_partner.sv
// Neighbour on the link: event pulses and the training level.
// Assumes the bench drives fire, want and trained after rising edges.
`timescale 1ns/1ps
`default_nettype none
module lcr_link_partner (
  input  wire logic                  aclk,
  input  wire logic                  fire,
  input  wire lcr_pkg::link_events_s want,
  input  wire logic                  trained,
  output lcr_pkg::link_events_s      events
);
  import lcr_pkg::*;
  always_ff @(posedge aclk) begin
    events           <= fire ? want : '0;
    events.init_done <= trained;
  end
endmodule : lcr_link_partner
`default_nettype wire

// ===== dv/link_control_register_checker.sv
// Checker for request, packet and control outputs of the register.
// Assumes one clock domain; bound onto link_control_register.
`timescale 1ns/1ps
`default_nettype none
module link_control_register_checker #(
  parameter int CTL_EXT_CYCLES = 8
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  warm_reset,
  input wire lcr_pkg::link_events_s events,
  input wire logic                  req_valid,
  input wire lcr_pkg::req_s         req,
  input wire logic                  pkt_valid,
  input wire logic                  pkt_nonposted,
  input wire lcr_pkg::link_ctrl_s   ctrl,
  input wire lcr_pkg::req_result_s  req_result,
  input wire logic                  pkt_drop,
  input wire logic                  pkt_nxa_response
);
  import lcr_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] ext_cnt;
  logic        ext_cut;
  // Length of the current extend run
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl.ctl_extend) ext_cnt <= 16'h0000;
    else ext_cnt <= ext_cnt + 16'h0001;
  end
  // Runs cut or restarted are not measured
  always_ff @(posedge aclk) begin
    if (!aresetn) ext_cut <= 1'b0;
    else if (warm_reset || events.stop_reinit) ext_cut <= 1'b1;
    else if (!ctrl.ctl_extend) ext_cut <= 1'b0;
  end
  ////////////////////////////////////////
  sequence high_req(logic en);
    req_valid && req.addr[63:40] != 24'h000000 && ctrl.addr64_enable == en
      ##1 ctrl.addr64_enable == en;
  endsequence
  sequence eoc_pkt(logic on);
    pkt_valid && ctrl.end_of_chain == on ##1 ctrl.end_of_chain == on;
  endsequence
  req_low_a: assert property (
    req_valid && req.addr[63:40] == 24'h000000 |=> req_result.done
      && req_result.accept && !req_result.master_abort) else $error("low request refused");
  req_abort_a: assert property (
    high_req(1'b0) |-> req_result.master_abort && !req_result.accept)
    else $error("high request not aborted");
  req_ext_a: assert property (
    high_req(1'b1) |-> req_result.forward_ext == $past(req.from_parallel)
      && req_result.accept == ($past(req.from_parallel) || $past(req.addr_ext_cmd)))
    else $error("enabled high request mishandled");
  pkt_drop_a: assert property (
    eoc_pkt(1'b1) |-> pkt_drop && pkt_nxa_response == $past(pkt_nonposted))
    else $error("packet at end of chain not dropped");
  pkt_pass_a: assert property (
    eoc_pkt(1'b0) |-> !pkt_drop && !pkt_nxa_response)
    else $error("packet dropped without end of chain");
  eoc_hold_a: assert property (
    ctrl.end_of_chain && !warm_reset && !$past(warm_reset) |=> ctrl.end_of_chain)
    else $error("end of chain cleared without warm reset");
  xmit_hold_a: assert property (
    ctrl.transmitter_shutdown_flag && !warm_reset && !$past(warm_reset)
      |=> ctrl.transmitter_shutdown_flag) else $error("shutdown cleared without reset");
  ext_len_a: assert property (
    $fell(ctrl.ctl_extend) && !ext_cut |-> ext_cnt == CTL_EXT_CYCLES)
    else $error("control extend length wrong");
endmodule : link_control_register_checker
`default_nettype wire
bind link_control_register link_control_register_checker #(
  .CTL_EXT_CYCLES(CTL_EXT_CYCLES)
) u_link_control_register_checker (
  .aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset), .events(events),
  .req_valid(req_valid), .req(req), .pkt_valid(pkt_valid), .pkt_nonposted(pkt_nonposted),
  .ctrl(ctrl), .req_result(req_result), .pkt_drop(pkt_drop),
  .pkt_nxa_response(pkt_nxa_response)
);

// ===== dv/link_control_register_bench.sv
// Self-checking bench for the link control register over AXI4-Lite.
// Assumes the bound checker and a control-extend count of 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module link_control_register_bench;
  import lcr_pkg::*;
  localparam int EXT = 8;
  logic aclk, aresetn, warm_reset, fire, trained, req_valid, pkt_valid, pkt_nonposted;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pkt_drop, pkt_nxa_response, pend, ext;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, d;
  logic [1:0]   s_axi_bresp, s_axi_rresp, r;
  logic [15:0]  m;
  profile_e     strap;
  link_events_s want, events;
  req_s         req;
  link_ctrl_s   ctrl;
  req_result_s  req_result;
  int           n_errors = 0, samples_checked = 0, seed;
  link_control_register #(.CTL_EXT_CYCLES(EXT)) u_link_control_register (
    .aclk, .aresetn, .warm_reset, .profile_strap(strap), .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .events, .req_valid, .req, .pkt_valid, .pkt_nonposted,
    .ctrl, .req_result, .pkt_drop, .pkt_nxa_response);
  lcr_link_partner u_lcr_link_partner (.aclk, .fire, .want, .trained, .events);
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    results();
  end
  ////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axw(logic [7:0] a, logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_bready <= 1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
  endtask : axw
  task automatic axr(logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr = 0;
    @(posedge aclk);
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
  endtask : axr
  task automatic rd();
    axr(8'h44, d, r);
    chk("link_ctrl", {16'h0000, m}, d);
    chk("rresp", 0, r);
  endtask : rd
  // Model of a full-word write
  task automatic wr(logic [15:0] v);
    axw(8'h44, {16'($urandom), v}, r);
    chk("bresp", 0, r);
    if (ext) m[15:13] = v[15:13];
    else m[14:12] = m[14:12] & ~v[14:12];
    m[11:8] = m[11:8] & ~v[11:8];
    m[7:6] = m[7:6] | v[7:6];
    m[3] = v[3];
    m[2] = m[2] | v[2];
    m[1] = v[1];
    pend = v[4];
  endtask : wr
  task automatic ev(logic [10:0] v);
    link_events_s e;
    e = v;
    @(posedge aclk);
    fire <= 1;
    want <= e;
    @(posedge aclk);
    fire <= 0;
    if (!ext) m[14:12] = m[14:12] | {e.eoc_drop, e.overflow, e.protocol};
    m[11:8] = m[11:8] | e.crc_lane;
    if ((e.crc_lane != 4'h0 && m[1]) || e.hw_fail) begin
      m[4] = 1;
      pend = 1;
    end
    if (e.crc_test_done) m[2] = 0;
  endtask : ev
  task automatic warm();
    @(posedge aclk);
    warm_reset <= 1;
    @(posedge aclk);
    warm_reset <= 0;
    m = m & (ext ? 16'h0F00 : 16'h7F00);
    m[4] = pend;
  endtask : warm
  task automatic cold(profile_e p);
    @(posedge aclk);
    aresetn <= 0;
    strap <= p;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    ext = (p == EXTENDED_SINGLE_PROFILE || p == EXTENDED_DUAL_PROFILE);
    m = 16'h0000;
    pend = 0;
  endtask : cold
  task automatic rq();
    logic [63:0] a;
    req_result_s e;
    a = {32'($urandom), 32'($urandom)};
    if (a[0]) a[63:40] = 24'h000000;
    e = 4'h8;
    if (a[63:40] == 24'h000000) e.accept = 1;
    else if (!(ext && m[15])) e.master_abort = 1;
    else if (a[1]) e = 4'hE;
    else if (a[2]) e.accept = 1;
    else e.master_abort = 1;
    @(posedge aclk);
    req_valid <= 1;
    req <= '{a, a[1], a[2]};
    @(posedge aclk);
    req_valid <= 0;
    @(negedge aclk);
    chk("req_result", e, req_result);
  endtask : rq
  task automatic pk(logic np);
    @(posedge aclk);
    pkt_valid <= 1;
    pkt_nonposted <= np;
    @(posedge aclk);
    pkt_valid <= 0;
    @(negedge aclk);
    chk("pkt_drop_nxa", {m[6], m[6] & np}, {pkt_drop, pkt_nxa_response});
  endtask : pk
  task automatic ext_len();
    int n = 0;
    ev(11'h001);
    repeat (20) begin
      @(negedge aclk);
      if (ctrl.ctl_extend === 1'b1) n++;
    end
    chk("ctl_extend_len", (ext && m[14]) ? EXT : 0, n);
  endtask : ext_len
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  ////////////////////////////////////////
  initial begin
    {aresetn, warm_reset, fire, trained, req_valid, pkt_valid, pkt_nonposted} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    strap = BASIC_SINGLE_PROFILE;
    want = '0;
    req = '0;
    seed = $urandom(38124);
    cold(BASIC_SINGLE_PROFILE);
    rd();
    axr(8'h48, d, r);
    chk("unmapped_read", 32'h2, {d[29:0], r});
    axw(8'h48, 32'hFFFF, r);
    chk("unmapped_bresp", 2, r);
    repeat (4) begin
      ev({3'b111, 4'($urandom), 4'h0});
      rd();
      wr(16'($urandom) & 16'hFF01);
      rd();
    end
    pk(1'b1);
    wr(16'h0040);
    wr(16'h008F);
    rd();
    chk("ctrl_on", 3'h7, {ctrl.transmitter_shutdown_flag, ctrl.force_bad_crc,
      ctrl.crc_test_run});
    pk(1'b1);
    pk(1'b0);
    wr(16'h0002);
    rd();
    ev(11'h002);
    rd();
    ev(11'h020);
    rd();
    chk("flood", 2'b10, {ctrl.sync_flood, ctrl.link_init_allowed});
    warm();
    rd();
    wr(16'h0000);
    rd();
    warm();
    rd();
    trained <= 1;
    repeat (2) @(posedge aclk);
    m[5] = 1;
    rd();
    trained <= 0;
    m[5] = 0;
    wr(16'h0010);
    rd();
    warm();
    rd();
    chk("init_blocked", 2'b01, {ctrl.link_init_allowed, ctrl.link_failure_flag});
    ext_len();
    repeat (6) rq();
    for (int p = 1; p < 3; p++) begin
      cold(profile_e'(p));
      rd();
      wr(16'hF000);
      ev(11'h700);
      rd();
      chk("ext_ctrl", 2'b11, {ctrl.addr64_enable, ctrl.tristate_on_stop});
      ext_len();
      repeat (12) rq();
      wr(16'h0000);
      rd();
      repeat (6) rq();
      ext_len();
    end
    results();
  end
endmodule : link_control_register_bench
`default_nettype wire
